/* rtl/t0ps_map.svh */
// register map, field positions, reset values and bus codes of the timer0 prescaler block
`ifndef T0PS_MAP_SVH
`define T0PS_MAP_SVH

// ============================================================
// register indices (byte address is four times the index)
`define T0PS_IDX_COUNT      10'h001
`define T0PS_IDX_INTC       10'h00B
`define T0PS_IDX_OPT        10'h081
`define T0PS_IDX_WDCMD      10'h00C

// ============================================================
// option_config fields
`define T0PS_OPT_PS_LSB     0
`define T0PS_OPT_PS_MSB     2
`define T0PS_OPT_ASSIGN     3
`define T0PS_OPT_EDGE       4
`define T0PS_OPT_SRC        5
`define T0PS_OPT_RESET      8'hFF

// ============================================================
// interrupt_control fields
`define T0PS_INTC_GLOBAL    7
`define T0PS_INTC_PERIPH    6
`define T0PS_INTC_T0IE      5
`define T0PS_INTC_T0IF      2
`define T0PS_INTC_RESET     8'h00

// ============================================================
// watchdog command register
`define T0PS_WDCMD_CLR      0

// ============================================================
// counters and bus codes
`define T0PS_CNT_ONES       8'hFF
`define T0PS_CNT_ONE        8'h01
`define T0PS_CNT_ZERO       8'h00
`define T0PS_SHIFT_ONE      4'h1
`define T0PS_HSIZE_WORD     3'h2
`define T0PS_HTRANS_ACTIVE  1
`define T0PS_DATA_ZERO      32'h0000_0000

`endif

/* rtl/t0ps_pkg.sv */
// types shared by the timer0 prescaler block
package t0ps_pkg;

    // ============================================================
    // bus data-phase state
    typedef enum logic [0:0] {
        T0PS_PH_IDLE,
        T0PS_PH_WRITE
    } t0ps_phase_t;

    // ============================================================
    // decoded register
    typedef enum logic [2:0] {
        T0PS_REG_NONE,
        T0PS_REG_COUNT,
        T0PS_REG_INTC,
        T0PS_REG_OPT,
        T0PS_REG_WDCMD
    } t0ps_reg_t;

endpackage : t0ps_pkg

/* rtl/t0ps_prescaler.sv */
// shared 8-bit prescaler with power-of-two tap select
`timescale 1ns/1ps
`default_nettype none
`include "t0ps_map.svh"

module t0ps_prescaler
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       tick_in,
    input  wire logic       clear,
    input  wire logic [3:0] shift,
    output logic            tick_out
);

    // ============================================================
    // tap mask: low "shift" bits set
    function automatic logic [7:0] t0ps_mask(input logic [3:0] s);
        logic [7:0] m;
        m = `T0PS_CNT_ZERO;
        for (int i = 0; i < 8; i++)
        begin
            m[i] = (4'(i) < s);
        end
        return m;
    endfunction : t0ps_mask

    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic [7:0] mask;

    // ============================================================
    // count and tap
    always_comb
    begin
        mask     = t0ps_mask(shift);
        tick_out = tick_in & ~clear & ((cnt_q & mask) == mask);
        cnt_d    = cnt_q;
        if (clear)
        begin
            cnt_d = `T0PS_CNT_ZERO;
        end
        else if (tick_in)
        begin
            cnt_d = cnt_q + `T0PS_CNT_ONE;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q <= `T0PS_CNT_ZERO;
        end
        else
        begin
            cnt_q <= cnt_d;
        end
    end

endmodule : t0ps_prescaler

`default_nettype wire

/* rtl/t0ps_top.sv */
// timer0 with shared timer/watchdog prescaler behind an AHB-Lite slave
//
// How it works
// - prescale_select picks 1:2..1:256 for timer0, 1:1..1:128 for watchdog.
// - a write to timer0_count clears the prescaler when timer0 owns it.
// - watchdog clear resets watchdog counter and prescaler when watchdog owns it.
// - timer0_count is undefined at power-up and kept across later resets.
// - prescaler_assign high routes prescaler to watchdog, low to timer0.
// - a timer0_count write leaves prescaler_assign unchanged.
// - the prescaler count has no software read or write path.
`timescale 1ns/1ps
`default_nettype none
`include "t0ps_map.svh"

module t0ps_top
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        t0cki,
    input  wire logic        wdt_osc_tick,
    output logic             timer0_irq,
    output logic             wdt_timeout
);

    // ============================================================
    // address decode
    function automatic t0ps_pkg::t0ps_reg_t t0ps_decode(input logic [11:0] a);
        t0ps_pkg::t0ps_reg_t r;
        r = t0ps_pkg::T0PS_REG_NONE;
        if (a[1:0] != 2'h0)
        begin
            r = t0ps_pkg::T0PS_REG_NONE;
        end
        else if (a[11:2] == `T0PS_IDX_COUNT)
        begin
            r = t0ps_pkg::T0PS_REG_COUNT;
        end
        else if (a[11:2] == `T0PS_IDX_INTC)
        begin
            r = t0ps_pkg::T0PS_REG_INTC;
        end
        else if (a[11:2] == `T0PS_IDX_OPT)
        begin
            r = t0ps_pkg::T0PS_REG_OPT;
        end
        else if (a[11:2] == `T0PS_IDX_WDCMD)
        begin
            r = t0ps_pkg::T0PS_REG_WDCMD;
        end
        return r;
    endfunction : t0ps_decode

    // ============================================================
    // state
    t0ps_pkg::t0ps_phase_t phase_q;
    t0ps_pkg::t0ps_phase_t phase_d;
    t0ps_pkg::t0ps_reg_t   wsel_q;
    t0ps_pkg::t0ps_reg_t   wsel_d;
    t0ps_pkg::t0ps_reg_t   asel;
    logic                  access;
    logic                  wr_count;
    logic                  wr_intc;
    logic                  wr_opt;
    logic                  wdt_clr;
    logic [7:0]            count_q;
    logic [7:0]            count_d;
    logic [7:0]            intc_q;
    logic [7:0]            intc_d;
    logic [7:0]            opt_q;
    logic [7:0]            opt_d;
    logic [7:0]            wdt_cnt_q;
    logic [7:0]            wdt_cnt_d;
    logic                  t0cki_q;
    logic                  ps_to_wd;
    logic [2:0]            ps;
    logic                  ext_evt;
    logic                  tim_evt;
    logic                  ps_in;
    logic                  ps_clr;
    logic [3:0]            ps_shift;
    logic                  ps_tick;
    logic                  tim_inc;
    logic                  wdt_inc;
    logic                  ovf;
    logic                  wdt_wrap;
    logic [31:0]           hrdata_q;
    logic [31:0]           hrdata_d;
    logic                  irq_q;
    logic                  irq_d;
    logic                  wdt_to_q;
    logic                  hreadyout_q;
    logic                  hresp_q;

    // ============================================================
    // bus address phase and data-phase write strobes
    always_comb
    begin
        access  = hsel & hready & htrans[`T0PS_HTRANS_ACTIVE];
        asel    = t0ps_decode(haddr[11:0]);
        phase_d = t0ps_pkg::T0PS_PH_IDLE;
        wsel_d  = t0ps_pkg::T0PS_REG_NONE;
        if (access && hwrite && (hsize == `T0PS_HSIZE_WORD))
        begin
            phase_d = t0ps_pkg::T0PS_PH_WRITE;
            wsel_d  = asel;
        end
    end

    always_comb
    begin
        wr_count = 1'b0;
        wr_intc  = 1'b0;
        wr_opt   = 1'b0;
        wdt_clr  = 1'b0;
        case (phase_q)
            t0ps_pkg::T0PS_PH_WRITE:
            begin
                wr_count = (wsel_q == t0ps_pkg::T0PS_REG_COUNT);
                wr_intc  = (wsel_q == t0ps_pkg::T0PS_REG_INTC);
                wr_opt   = (wsel_q == t0ps_pkg::T0PS_REG_OPT);
                wdt_clr  = (wsel_q == t0ps_pkg::T0PS_REG_WDCMD) && hwdata[`T0PS_WDCMD_CLR];
            end
            default: ;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            phase_q     <= t0ps_pkg::T0PS_PH_IDLE;
            wsel_q      <= t0ps_pkg::T0PS_REG_NONE;
            hreadyout_q <= 1'b1;
            hresp_q     <= 1'b0;
        end
        else
        begin
            phase_q     <= phase_d;
            wsel_q      <= wsel_d;
            hreadyout_q <= 1'b1;
        end
    end

    // ============================================================
    // timer0 clock source and prescaler routing
    always_comb
    begin
        ps_to_wd = opt_q[`T0PS_OPT_ASSIGN];
        ps       = opt_q[`T0PS_OPT_PS_MSB:`T0PS_OPT_PS_LSB];
        // edge select high: count on falling edge of the pin
        ext_evt  = opt_q[`T0PS_OPT_EDGE] ? (t0cki_q & ~t0cki) : (~t0cki_q & t0cki);
        tim_evt  = opt_q[`T0PS_OPT_SRC] ? ext_evt : 1'b1;
        ps_in    = ps_to_wd ? wdt_osc_tick : tim_evt;
        // watchdog taps 2^ps, timer0 taps 2^(ps+1)
        ps_shift = ps_to_wd ? {1'b0, ps} : ({1'b0, ps} + `T0PS_SHIFT_ONE);
        // reassignment relies on software clearing before a switch
        ps_clr   = (wr_count & ~ps_to_wd) | (wdt_clr & ps_to_wd);
        tim_inc  = ps_to_wd ? tim_evt : ps_tick;
        wdt_inc  = ps_to_wd ? ps_tick : wdt_osc_tick;
    end

    // prescaler count stays internal, no bus path reaches it
    t0ps_prescaler u_prescaler
    (
        .clk      (hclk),
        .rst_n    (hresetn),
        .tick_in  (ps_in),
        .clear    (ps_clr),
        .shift    (ps_shift),
        .tick_out (ps_tick)
    );

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            t0cki_q <= 1'b0;
        end
        else
        begin
            t0cki_q <= t0cki;
        end
    end

    // ============================================================
    // timer0 count, overflow and interrupt
    always_comb
    begin
        count_d = count_q;
        ovf     = 1'b0;
        if (wr_count)
        begin
            count_d = hwdata[7:0];
        end
        else if (tim_inc)
        begin
            count_d = count_q + `T0PS_CNT_ONE;
            ovf     = (count_q == `T0PS_CNT_ONES);
        end
    end

    // no reset: undefined at power-up, unchanged by hresetn
    always_ff @(posedge hclk)
    begin
        count_q <= count_d;
    end

    always_comb
    begin
        intc_d = intc_q;
        if (wr_intc)
        begin
            intc_d = hwdata[7:0];
        end
        // a wrap in the clearing cycle still sets the flag
        if (ovf)
        begin
            intc_d[`T0PS_INTC_T0IF] = 1'b1;
        end
        irq_d = intc_d[`T0PS_INTC_GLOBAL] &
                intc_d[`T0PS_INTC_T0IE] &
                intc_d[`T0PS_INTC_T0IF];
    end

    // ============================================================
    // option register; assignment changes only through this write
    always_comb
    begin
        opt_d = opt_q;
        if (wr_opt)
        begin
            opt_d = hwdata[7:0];
        end
    end

    // ============================================================
    // watchdog counter
    always_comb
    begin
        wdt_cnt_d = wdt_cnt_q;
        wdt_wrap  = 1'b0;
        if (wdt_clr)
        begin
            wdt_cnt_d = `T0PS_CNT_ZERO;
        end
        else if (wdt_inc)
        begin
            wdt_cnt_d = wdt_cnt_q + `T0PS_CNT_ONE;
            wdt_wrap  = (wdt_cnt_q == `T0PS_CNT_ONES);
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            intc_q    <= `T0PS_INTC_RESET;
            opt_q     <= `T0PS_OPT_RESET;
            wdt_cnt_q <= `T0PS_CNT_ZERO;
            irq_q     <= 1'b0;
            wdt_to_q  <= 1'b0;
        end
        else
        begin
            intc_q    <= intc_d;
            opt_q     <= opt_d;
            wdt_cnt_q <= wdt_cnt_d;
            irq_q     <= irq_d;
            wdt_to_q  <= wdt_wrap;
        end
    end

    // ============================================================
    // read data, taken from next values so a preceding write shows
    always_comb
    begin
        hrdata_d = hrdata_q;
        if (access && !hwrite)
        begin
            if (asel == t0ps_pkg::T0PS_REG_COUNT)
            begin
                hrdata_d = {24'h00_0000, count_d};
            end
            else if (asel == t0ps_pkg::T0PS_REG_INTC)
            begin
                hrdata_d = {24'h00_0000, intc_d};
            end
            else if (asel == t0ps_pkg::T0PS_REG_OPT)
            begin
                hrdata_d = {24'h00_0000, opt_d};
            end
            else if (asel == t0ps_pkg::T0PS_REG_WDCMD)
            begin
                hrdata_d = {24'h00_0000, wdt_cnt_d};
            end
            else
            begin
                hrdata_d = `T0PS_DATA_ZERO;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata_q <= `T0PS_DATA_ZERO;
        end
        else
        begin
            hrdata_q <= hrdata_d;
        end
    end

    // ============================================================
    // outputs
    assign hrdata      = hrdata_q;
    assign hreadyout   = hreadyout_q;
    assign hresp       = hresp_q;
    assign timer0_irq  = irq_q;
    assign wdt_timeout = wdt_to_q;

endmodule : t0ps_top

`default_nettype wire

/* verif/t0ps_props.sv */
// assertion checker for the timer0 prescaler slave
`timescale 1ns/1ps
`default_nettype none
module t0ps_props
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        timer0_irq,
    input wire logic        wdt_timeout
);
    // ============================================================
    // bus tracking
    logic        rd_q;
    logic        wr_q;
    logic [11:0] a_q;
    logic [7:0]  opt_q;
    wire         tk = hsel & hready & htrans[1];

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rd_q  <= 1'b0;
            wr_q  <= 1'b0;
            a_q   <= 12'h000;
            opt_q <= 8'hFF;
        end
        else
        begin
            rd_q <= tk & !hwrite;
            wr_q <= tk & hwrite & (hsize == 3'h2);
            if (tk)
                a_q <= haddr[11:0];
            if (wr_q && a_q == 12'h204)
                opt_q <= hwdata[7:0];
        end
    end

    // ============================================================
    // properties
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    ready_high_a: assert property (hreadyout)
        else $error("hreadyout low");
    resp_okay_a: assert property (!hresp)
        else $error("hresp not okay");
    upper_zero_a: assert property (rd_q |-> hrdata[31:8] == 24'h0)
        else $error("upper read bits set");
    hole_zero_a: assert property (rd_q && !(a_q inside {12'h004, 12'h02C, 12'h204, 12'h030})
        |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    opt_back_a: assert property (rd_q && a_q == 12'h204 |-> hrdata[7:0] == opt_q)
        else $error("option readback wrong");
    irq_match_a: assert property (rd_q && a_q == 12'h02C
        |-> (hrdata[7] & hrdata[5] & hrdata[2]) == timer0_irq)
        else $error("irq disagrees with control bits");
    quiet_start_a: assert property ($rose(hresetn) |-> !timer0_irq && !wdt_timeout)
        else $error("outputs active after reset");
    wdt_pulse_a: assert property (wdt_timeout |=> !wdt_timeout)
        else $error("timeout pulse too long");

    cover property (rd_q && a_q == 12'h02C && hrdata[2]);
    cover property (rd_q && a_q == 12'h204);
    cover property (wdt_timeout);
endmodule : t0ps_props
bind t0ps_top t0ps_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .timer0_irq(timer0_irq), .wdt_timeout(wdt_timeout));
`default_nettype wire

/* verif/tb_top.sv */
// self-checking bench for the timer0 prescaler slave
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [11:0] a_cnt  = 12'h004;
    localparam logic [11:0] a_intc = 12'h02C;
    localparam logic [11:0] a_opt  = 12'h204;
    localparam logic [11:0] a_wd   = 12'h030;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic        t0cki = 1'b0;
    logic        wdt_osc_tick = 1'b0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        timer0_irq;
    logic        wdt_timeout;
    logic [31:0] rd;
    int          bad_count = 0;
    int          comparisons = 0;
    int          hits = 0;
    logic [7:0]  iv [3] = '{8'h24, 8'hA4, 8'h84};

    always #20 hclk = ~hclk;
    always @(posedge hclk)
        if (wdt_timeout === 1'b1)
            hits++;

    t0ps_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .t0cki(t0cki), .wdt_osc_tick(wdt_osc_tick), .timer0_irq(timer0_irq),
        .wdt_timeout(wdt_timeout));

    // ============================================================
    // bus tasks
    task automatic idle(input int n);
        repeat (n) @(posedge hclk);
    endtask : idle

    task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
        hsel   <= 1'b1;
        haddr  <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : cmp

    task automatic check(input logic [11:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        cmp(rd, {24'h0, e});
    endtask : check

    task automatic tick(input int n);
        repeat (n)
        begin
            wdt_osc_tick <= 1'b1;
            idle(1);
            wdt_osc_tick <= 1'b0;
            idle(1);
        end
    endtask : tick

    task automatic end_of_test;
        $display("mismatches %0d, comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_of_test

    initial
    begin
        repeat (20000) @(posedge hclk);
        bad_count++;
        end_of_test();
    end

    // ============================================================
    // tests
    initial
    begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        idle(1);
        check(a_opt, 8'hFF);
        check(a_intc, 8'h00);
        wr(12'h3FC, 8'h55);
        check(12'h3FC, 8'h00);
        check(12'h006, 8'h00);
        // pin source, no edges: count must survive a reset
        wr(a_cnt, 8'h5A);
        hresetn <= 1'b0;
        idle(2);
        hresetn <= 1'b1;
        idle(1);
        check(a_cnt, 8'h5A);
        repeat (3)
        begin
            t0cki <= 1'b1;
            idle(2);
            t0cki <= 1'b0;
            idle(2);
        end
        check(a_cnt, 8'h5D);
        // pin source, rising edge selected: only the rise counts
        wr(a_opt, 8'h28);
        t0cki <= 1'b1;
        idle(2);
        check(a_cnt, 8'h5E);
        t0cki <= 1'b0;
        idle(2);
        check(a_cnt, 8'h5E);
        for (int ps = 0; ps < 8; ps++)
        begin
            wr(a_opt, 8'(ps));
            wr(a_cnt, 8'h00);
            idle((7 << ps) - 1);
            check(a_cnt, 8'h03);
        end
        wr(a_cnt, 8'h00);
        idle(200);
        wr(a_cnt, 8'h10);
        idle(200);
        check(a_cnt, 8'h10);
        check(a_opt, 8'h07);
        wr(a_cnt, 8'h00);
        wr(a_opt, 8'h0F);
        wr(a_wd, 8'h01);
        wr(a_opt, 8'h09);
        tick(3);
        check(a_wd, 8'h01);
        wr(a_wd, 8'h01);
        tick(1);
        check(a_wd, 8'h00);
        tick(1);
        check(a_wd, 8'h01);
        wr(a_wd, 8'h01);
        wr(a_opt, 8'h00);
        wr(a_intc, 8'hA0);
        wr(a_cnt, 8'hFE);
        idle(8);
        check(a_intc, 8'hA4);
        cmp({31'h0, timer0_irq}, 32'h1);
        wr(a_intc, 8'hA0);
        idle(1);
        cmp({31'h0, timer0_irq}, 32'h0);
        for (int i = 0; i < 3; i++)
        begin
            wr(a_intc, iv[i]);
            idle(1);
            cmp({31'h0, timer0_irq}, {31'h0, iv[i][7] & iv[i][5]});
        end
        wr(a_opt, 8'h08);
        tick(300);
        cmp(32'(hits > 0), 32'h1);
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
